//--- hw/udma_consts.vh
`ifndef UDMA_CONSTS_VH
`define UDMA_CONSTS_VH
// Clock period of clk_sys in picoseconds
`define CLK_PERIOD_PS 5000
// Least delay before driving data after the start condition, in ps
`define DRIVE_DELAY_MIN_PS 0
// Cycles for that delay, at least one
`define DRIVE_DELAY_CYC ((`DRIVE_DELAY_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS + 1)
// Pause once free room in the receive buffer falls below this many words
`define NEAR_FULL_ROOM 2
// Receive depth of the two-entry buffer
`define BUF_DEPTH 2
// Sender states
`define ST_IDLE 2'h0
`define ST_RUN 2'h1
`define ST_PAUSE 2'h2
`endif

//--- hw/udma_skid_buf.v
`timescale 1ns/10ps
`default_nettype none
// Two-entry buffer with valid and ready on both sides
module udma_skid_buf #(
  parameter WIDTH = 16
) (
  input wire clk_sys,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [1:0] level
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers and fill count
  always @(posedge clk_sys) begin
    if (srst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage has no reset; valid is carried by the count
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // udma_skid_buf
`default_nettype wire

//--- hw/udma_burst_ctrl.v
// What this block does
// - Data bus is driven only after both stop negated and host ready asserted are seen.
// - Stop negated with host ready asserted is taken as proof of an Ultra DMA host.
// - Drive starts a minimum of 0 ns after the start condition, after synchronisation.
// - The receiver drops its ready from a near-full level, not in step with strobes.
// - The one-extra-word bound holds only in modes 0 to 2.
// - Seeing ready negated, the sender stops strobing; a strobe due next edge is dropped.
// - A two-period synchronisation is allowed if no strobe goes out until resumed.
// - A late capture may let one more strobe out, which the receiver must take.
`timescale 1ns/10ps
`default_nettype none
`include "udma_consts.vh"
module udma_burst_ctrl #(
  parameter WIDTH = 16,
  parameter STROBE_DIV = 4,
  parameter PAUSE_SYNC_CYC = 1
) (
  input wire clk_sys,
  input wire srst,
  input wire dmack_n,
  input wire stop_in,
  input wire hdmardy_n_in,
  input wire data_in_dir,
  input wire hstrobe_in,
  input wire [WIDTH-1:0] dd_in,
  output reg [WIDTH-1:0] dd_out,
  output reg dd_oe,
  output reg dstrobe_out,
  output reg dstrobe_oe,
  output wire ddmardy_n_out,
  output reg ddmardy_oe,
  input wire tx_valid,
  output wire tx_ready,
  input wire [WIDTH-1:0] tx_data,
  output wire rx_valid,
  input wire rx_ready,
  output wire [WIDTH-1:0] rx_data,
  output reg paused
);
  // Three-stage synchronisers for every link input
  reg [2:0] ack_s_q;
  reg [2:0] stop_s_q;
  reg [2:0] rdy_s_q;
  reg [2:0] hs_s_q;
  reg [WIDTH-1:0] dd_s1_q;
  reg [WIDTH-1:0] dd_s2_q;
  reg [WIDTH-1:0] dd_s3_q;
  reg ack_q;
  reg stop_q;
  reg rdy_n_q;
  reg hs_q;
  reg hs_prev_q;

  always @(posedge clk_sys) begin
    if (srst) begin
      ack_s_q <= 3'h7;
      stop_s_q <= 3'h7;
      rdy_s_q <= 3'h7;
      hs_s_q <= 3'h7;
      dd_s1_q <= {WIDTH{1'b0}};
      dd_s2_q <= {WIDTH{1'b0}};
      dd_s3_q <= {WIDTH{1'b0}};
      ack_q <= 1'b0;
      stop_q <= 1'b1;
      rdy_n_q <= 1'b1;
      hs_q <= 1'b1;
      hs_prev_q <= 1'b1;
    end else begin
      ack_s_q <= {ack_s_q[1:0], dmack_n};
      stop_s_q <= {stop_s_q[1:0], stop_in};
      rdy_s_q <= {rdy_s_q[1:0], hdmardy_n_in};
      hs_s_q <= {hs_s_q[1:0], hstrobe_in};
      dd_s1_q <= dd_in;
      dd_s2_q <= dd_s1_q;
      dd_s3_q <= dd_s2_q; // Settled long before the strobe edge counts
      // A level counts once the second and third stages agree
      if (ack_s_q[1] == ack_s_q[2]) begin
        ack_q <= ~ack_s_q[2];
      end
      if (stop_s_q[1] == stop_s_q[2]) begin
        stop_q <= stop_s_q[2];
      end
      if (rdy_s_q[1] == rdy_s_q[2]) begin
        rdy_n_q <= rdy_s_q[2];
      end
      if (hs_s_q[1] == hs_s_q[2]) begin
        hs_q <= hs_s_q[2];
      end
      hs_prev_q <= hs_q;
    end
  end

  // Start condition only legal in Ultra DMA: both host lines "asserted" in old terms
  wire start_ok = ack_q & ~stop_q & ~rdy_n_q;
  wire host_rdy = ~rdy_n_q;

  // Send path: host data words leave the buffer one per strobe edge
  wire tx_bv;
  reg tx_pop;
  wire [WIDTH-1:0] tx_bd;

  udma_skid_buf #(.WIDTH(WIDTH)) u_tx_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(tx_bv),
    .out_ready(tx_pop),
    .out_data(tx_bd),
    .level()
  );

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] div_q;
  reg [3:0] wait_q;
  reg [7:0] psync_q;
  wire sync_done = (psync_q >= PAUSE_SYNC_CYC[7:0]);
  wire div_hit = (div_q == STROBE_DIV[7:0] - 8'h01);

  // Sender state: run, or held while host ready is negated
  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE: begin
        if (start_ok && data_in_dir && wait_q == `DRIVE_DELAY_CYC) begin
          state_d = `ST_RUN;
        end
      end
      `ST_RUN: begin
        if (!ack_q) begin
          state_d = `ST_IDLE;
        end else if (!host_rdy && sync_done) begin
          state_d = `ST_PAUSE;
        end
      end
      `ST_PAUSE: begin
        if (!ack_q) begin
          state_d = `ST_IDLE;
        end else if (host_rdy) begin
          state_d = `ST_RUN;
        end
      end
      default: begin
        state_d = `ST_IDLE;
      end
    endcase
  end

  // Strobe generation; a strobe due on the pause edge is withheld
  always @* begin
    tx_pop = (state_q == `ST_RUN) && div_hit && tx_bv && host_rdy && !sync_done;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_q <= `ST_IDLE;
      div_q <= 8'h00;
      wait_q <= 4'h0;
      psync_q <= 8'h00;
      dd_out <= {WIDTH{1'b0}};
      dd_oe <= 1'b0;
      dstrobe_out <= 1'b1;
      dstrobe_oe <= 1'b0;
      paused <= 1'b0;
    end else begin
      state_q <= state_d;
      // Minimum drive delay counted after both lines are synchronised
      if (!start_ok || !data_in_dir) begin
        wait_q <= 4'h0;
      end else if (wait_q != `DRIVE_DELAY_CYC) begin
        wait_q <= wait_q + 4'h1;
      end
      div_q <= div_hit ? 8'h00 : div_q + 8'h01;
      // Pause synchronisation allowance, configurable per clock rate
      if (host_rdy || state_q != `ST_RUN) begin
        psync_q <= 8'h00;
      end else if (!sync_done) begin
        psync_q <= psync_q + 8'h01;
      end
      dd_oe <= (state_d != `ST_IDLE);
      dstrobe_oe <= (state_d != `ST_IDLE);
      if (tx_pop) begin
        dd_out <= tx_bd;
        dstrobe_out <= ~dstrobe_out;
      end
      if (state_d == `ST_IDLE) begin
        dstrobe_out <= 1'b1;
      end
      paused <= (state_d == `ST_PAUSE);
    end
  end

  // Receive path: words caught on each host strobe edge
  wire [1:0] rx_level;
  wire rx_in_ready;
  wire rx_edge = ack_q && !data_in_dir && (hs_q != hs_prev_q);

  udma_skid_buf #(.WIDTH(WIDTH)) u_rx_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(rx_edge),
    .in_ready(rx_in_ready),
    .in_data(dd_s3_q),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .level(rx_level)
  );

  // Ready drops on level alone, with room left for the late extra word
  reg rx_hold_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      rx_hold_q <= 1'b1;
      ddmardy_oe <= 1'b0;
    end else begin
      rx_hold_q <= (rx_level + `NEAR_FULL_ROOM > `BUF_DEPTH);
      ddmardy_oe <= ack_q && !data_in_dir;
    end
  end
  assign ddmardy_n_out = rx_hold_q;
endmodule // udma_burst_ctrl
`default_nettype wire

//--- testbench/udma_burst_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Burst start, pacing and pause
module udma_burst_ctrl_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic dmack_n,
  input wire logic stop_in,
  input wire logic hdmardy_n_in,
  input wire logic dd_oe,
  input wire logic dstrobe_out,
  input wire logic ddmardy_n_out,
  input wire logic rx_valid,
  input wire logic paused
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire go_ok = !stop_in && !hdmardy_n_in && !dmack_n;
  a_reset_idle: assert property ($fell(srst) |-> !dd_oe && !paused)
    else $error("busy after reset");
  a_drive_cause: assert property ($rose(dd_oe) |-> $past(go_ok, 2))
    else $error("early drive");
  a_drive_mode: assert property ($rose(dd_oe) |-> !stop_in && !dmack_n)
    else $error("drive out of burst");
  a_drive_soon: assert property ($rose(go_ok) |-> ##[1:12] dd_oe)
    else $error("late drive");
  a_strobe_gap: assert property ($changed(dstrobe_out) |=> $stable(dstrobe_out) [*3])
    else $error("strobes too close");
  a_pause_soon: assert property ($rose(hdmardy_n_in) && !stop_in && dd_oe
    |-> ##[1:10] paused) else $error("no pause");
  a_pause_still: assert property (paused [*3] |-> $stable(dstrobe_out))
    else $error("strobe in pause");
  a_full_stall: assert property (rx_valid |=> ddmardy_n_out)
    else $error("ready while full");
  c_drive: cover property ($rose(dd_oe));
  c_pause: cover property ($rose(paused));
  c_stall: cover property (rx_valid && ddmardy_n_out);
endmodule // udma_burst_ctrl_chk
bind udma_burst_ctrl udma_burst_ctrl_chk udma_burst_ctrl_chk_i (.clk_sys, .srst, .dmack_n,
  .stop_in, .hdmardy_n_in, .dd_oe, .dstrobe_out, .ddmardy_n_out, .rx_valid, .paused);
`default_nettype wire

//--- testbench/udma_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host end: envelope, strobes, pause
module udma_host_model #(parameter ENV = 1) (
  input wire logic hclk,
  input wire logic go,
  input wire logic dir,
  input wire logic hold,
  input wire logic rdy_n,
  output logic dmack_n = 1,
  output logic stop_in = 1,
  output logic hdmardy_n_in = 1,
  output logic hstrobe_in = 1,
  output logic [15:0] dd_in = 0
);
  int env = 0;
  logic rs_a = 1'b1;
  logic rs_b = 1'b1;
  // Second ready flop on the inactive edge, so at most one late strobe slips out
  always @(negedge hclk) begin
    rs_b <= rs_a;
  end
  // Ready caught on the active edge
  always @(posedge hclk) begin
    rs_a <= rdy_n;
    env <= go ? env + 1 : 0;
    dmack_n <= !go;
    if (!go) begin
      stop_in <= 1;
      hdmardy_n_in <= 1;
      dd_in <= 16'hffff;
    end else if (env >= ENV) begin
      stop_in <= 0;
      hdmardy_n_in <= !dir | hold;
      if (dir)
        dd_in <= ~dd_in; // Released bus keeps no word
      if (!dir && !rs_b) begin
        hstrobe_in <= ~hstrobe_in;
        dd_in <= dd_in + 1;
      end
    end
  end
endmodule // udma_host_model
`default_nettype wire

//--- testbench/udma_burst_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module udma_burst_ctrl_tb_top;
  logic clk_sys = 0, srst = 1, hclk = 0, go = 0, dir = 1, hold = 0, tx_valid = 0, rx_ready = 1;
  logic ps = 1, dmack_n, stop_in, hdmardy_n_in, hstrobe_in, dd_oe, dstrobe_out, ddmardy_n_out;
  logic ddmardy_oe, dstrobe_oe, tx_ready, rx_valid, paused;
  logic [15:0] tx_data = 0, dd_in, dd_out, rx_data;
  int n_errors = 0, check_count = 0, ni = 0, nr = 0, cyc = 0;
  // Data-in words, also the values due on the bus
  logic [15:0] rows [4] = '{16'h0001, 16'hfffe, 16'ha55a, 16'h8000};
  wire rdy_n = ddmardy_oe ? ddmardy_n_out : 1'b1; // Host pull-up
  always #2.5 clk_sys = ~clk_sys;
  initial #1.3 forever #40 hclk = ~hclk; // Link clock, free phase
  udma_burst_ctrl udma_burst_ctrl_i (.clk_sys, .srst, .dmack_n, .stop_in, .hdmardy_n_in,
    .data_in_dir(dir), .hstrobe_in, .dd_in, .dd_out, .dd_oe, .dstrobe_out, .dstrobe_oe,
    .ddmardy_n_out, .ddmardy_oe, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready,
    .rx_data, .paused);
  udma_host_model udma_host_model_i (.hclk, .go, .dir, .hold, .rdy_n, .dmack_n, .stop_in,
    .hdmardy_n_in, .hstrobe_in, .dd_in);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t: %h not %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("%0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Word check on each strobe edge; hang guard
  always @(posedge clk_sys) begin
    ps <= dstrobe_out;
    cyc <= cyc + 1;
    if (dd_oe === 1'b1 && dstrobe_out !== ps && ni < 4) begin
      chk(dd_out, rows[ni]);
      ni <= ni + 1;
    end
    if (rx_valid === 1'b1 && rx_ready) begin
      chk(rx_data, nr[15:0]);
      nr <= nr + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    repeat (2) @(posedge clk_sys);
    chk(dd_oe, 0);
    chk(dstrobe_oe, 0);
    chk(ddmardy_oe, 0);
    $display("reset test end");
    tx_valid <= 1;
    for (int i = 0; i < 4; i++) begin
      tx_data <= rows[i];
      if (i == 2) begin
        repeat (20) @(posedge clk_sys);
        chk(tx_ready, 0);
        chk(dd_oe, 0);
        go <= 1;
      end
      do @(posedge clk_sys); while (tx_ready !== 1'b1);
    end
    tx_valid <= 0;
    hold <= 1;
    repeat (60) @(posedge clk_sys);
    chk(paused, 1);
    chk(dstrobe_oe, 1);
    hold <= 0;
    repeat (2000) if (ni < 4) @(posedge clk_sys);
    chk(ni[15:0], 4);
    repeat (20) @(posedge clk_sys);
    go <= 0;
    $display("data-in test end");
    // Data-out with the receiver stalled first
    repeat (40) @(posedge clk_sys);
    dir <= 0;
    rx_ready <= 0;
    go <= 1;
    repeat (300) @(posedge clk_sys);
    chk(rx_valid, 1);
    chk(ddmardy_n_out, 1);
    chk(ddmardy_oe, 1);
    rx_ready <= 1;
    repeat (3000) if (nr < 6) @(posedge clk_sys);
    chk(nr[15:0], 6);
    go <= 0;
    $display("data-out test end");
    print_verdict;
  end
endmodule // udma_burst_ctrl_tb_top
`default_nettype wire
